// >>> bench/dpm_board.sv
`timescale 1ns/1ps
`default_nettype none

// ------
// board: pull-ups on every pin, bench drivers, reset switch
// ------
module dpm_board (
  input  wire logic [13:0] pin_out,
  input  wire logic [13:0] pin_oe,
  input  wire logic [13:0] ext_oe,
  input  wire logic [13:0] ext_val,
  input  wire logic        rst_req,
  output logic [13:0]      pin_in,
  output logic             ext_reset_low
);
  // device drive wins, then a board driver, else the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
  // reset pin held inactive unless a reset is asked for
  assign ext_reset_low = ~rst_req;
endmodule
`default_nettype wire

// >>> bench/dpm_mux_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpm_params.svh"

// ------
// port checks for the pin mux
// ------
module dpm_mux_chk
  import dpm_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               srst,
  input wire logic               ext_reset_low,
  input wire logic               cfg_valid,
  input wire dpm_pkg::dpm_fuse_s cfg,
  input wire logic               i2c_if_en,
  input wire dpm_pkg::dpm_func_s func,
  input wire logic               host_fn_wr,
  input wire logic [13:0]        host_fn_mask,
  input wire logic               host_io_wr,
  input wire logic [13:0]        host_io_mask,
  input wire logic [13:0]        host_io_dir,
  input wire logic [13:0]        host_io_val,
  input wire logic [13:0]        pin_in,
  input wire logic [13:0]        pin_out,
  input wire logic [13:0]        pin_oe,
  input wire logic [13:0]        gp_mode,
  input wire logic               cfg_loaded,
  input wire logic [1:0]         drive_strength,
  input wire logic               remote_wake,
  input wire logic               int_reset
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // pins an io write may touch, and those it turns to outputs
  logic [13:0] io_m;
  logic [13:0] io_d;
  assign io_m = host_io_mask & gp_mode;
  assign io_d = io_m & host_io_dir;

  property p_io_dir;
    host_io_wr && !host_fn_wr && cfg_loaded
      |-> ##2 (pin_oe & $past(io_m, 2)) == ($past(host_io_dir, 2) & $past(io_m, 2));
  endproperty
  property p_io_val;
    host_io_wr && !host_fn_wr && cfg_loaded
      |-> ##2 (pin_out & $past(io_d, 2)) == ($past(host_io_val, 2) & $past(io_d, 2));
  endproperty
  property p_i2c_keep;
    host_fn_wr && host_fn_mask[5] && (i2c_if_en || cfg.eeprom_present) && !gp_mode[5]
      |=> !gp_mode[5];
  endproperty
  property p_load;
    (ext_reset_low && !int_reset)[*6] ##0 (!cfg_loaded && cfg_valid) |-> ##[1:2] cfg_loaded;
  endproperty
  property p_drive;
    cfg_loaded && $past(cfg_loaded) |-> drive_strength == cfg.drive;
  endproperty
  property p_charger;
    $rose(func.charger_dedicated) && cfg_loaded && !gp_mode[12] && cfg.pin12_sel == 2'h0
      && !host_fn_wr |-> ##[1:2] (pin_out[12] && pin_oe[12]);
  endproperty
  property p_tx_en;
    $rose(func.tx_active) && cfg_loaded && !gp_mode[0] && cfg.pin0_sel == 2'h0
      && !host_fn_wr |-> ##[1:2] (pin_out[0] && pin_oe[0]);
  endproperty
  property p_ext_rst;
    (!ext_reset_low)[*7] |-> int_reset && !cfg_loaded && gp_mode == 14'h0000;
  endproperty
  property p_wake;
    (cfg_loaded && !gp_mode[8] && cfg.pin8_sel == `DPM_PIN8_WAKE && !pin_in[8])[*6]
      |-> remote_wake;
  endproperty

  a_io_dir: assert property (p_io_dir) else $error("io direction not applied");
  a_io_val: assert property (p_io_val) else $error("io value not applied");
  a_i2c_keep: assert property (p_i2c_keep) else $error("i2c pin left its function");
  a_load: assert property (p_load) else $error("parameters not loaded");
  a_drive: assert property (p_drive) else $error("drive strength wrong");
  a_charger: assert property (p_charger) else $error("charger output missing");
  a_tx_en: assert property (p_tx_en) else $error("tx driver enable missing");
  a_ext_rst: assert property (p_ext_rst) else $error("external reset ignored");
  a_wake: assert property (p_wake) else $error("wake input ignored");

  c_io: cover property (host_io_wr && cfg_loaded);
  c_ext: cover property ((!ext_reset_low)[*7]);
  c_load: cover property ($rose(cfg_loaded));
endmodule
`default_nettype wire

// >>> bench/dpm_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module dpm_mux_tb;
  import dpm_pkg::*;
  logic             core_clk;
  logic             srst = 1'b1;
  logic             cfg_valid = 1'b0;
  logic             uart_if_en = 1'b0;
  logic             i2c_if_en = 1'b1;
  logic             host_fn_wr = 1'b0;
  logic             host_io_wr = 1'b0;
  logic             rst_req = 1'b0;
  dpm_fuse_s        cfg = '0;
  dpm_func_s        func = 9'h17E;
  logic [13:0]      host_fn_mask = '0, host_fn_gp = '0;
  logic [13:0]      host_io_mask = '0, host_io_dir = '0, host_io_val = '0;
  logic [13:0]      ext_oe = '0, ext_val = '0;
  logic [13:0]      pin_in, pin_out, pin_oe, host_io_level, gp_mode;
  logic [1:0]       drive_strength;
  logic             ext_reset_low, cfg_loaded, uart_rxd, scl_in, sda_in;
  logic             remote_wake, int_reset;
  logic [2:0]       oe3;
  int               fail_count = 0, checks_done = 0, cyc = 0;
  localparam logic [11:0] OUT_TBL = 12'h035;
  localparam logic [11:0] OE_TBL = 12'h1BF;

  dpm_mux dut (.core_clk, .srst, .ext_reset_low, .cfg_valid, .cfg, .uart_if_en, .i2c_if_en,
    .func, .host_fn_wr, .host_fn_mask, .host_fn_gp, .host_io_wr, .host_io_mask, .host_io_dir,
    .host_io_val, .pin_in, .pin_out, .pin_oe, .host_io_level, .gp_mode, .cfg_loaded,
    .drive_strength, .uart_rxd, .scl_in, .sda_in, .remote_wake, .int_reset);
  dpm_board board (.pin_out, .pin_oe, .ext_oe, .ext_val, .rst_req, .pin_in, .ext_reset_low);

  assign oe3 = {pin_oe[12], pin_oe[7], pin_oe[0]};

  // ------
  // clock, timeout, tasks
  // ------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic fn_wr(input logic [13:0] m, input logic [13:0] g);
    host_fn_mask = m;
    host_fn_gp = g;
    host_fn_wr = 1'b1;
    step(1);
    host_fn_wr = 1'b0;
    step(2);
  endtask
  task automatic io_wr(input logic [13:0] m, input logic [13:0] d, input logic [13:0] v);
    host_io_mask = m;
    host_io_dir = d;
    host_io_val = v;
    host_io_wr = 1'b1;
    step(1);
    host_io_wr = 1'b0;
    step(2);
  endtask
  task automatic wait_load();
    for (int i = 0; i < 20 && cfg_loaded !== 1'b1; i++) begin
      step(1);
    end
    step(8);
    `CHK("loaded", 1'b1, cfg_loaded)
  endtask
  task automatic boot(input dpm_fuse_s c, input logic u);
    srst = 1'b1;
    cfg_valid = 1'b0;
    cfg = c;
    uart_if_en = u;
    step(8);
    srst = 1'b0;
    step(8);
    `CHK("early load", 1'b0, cfg_loaded)
    cfg_valid = 1'b1;
    wait_load();
  endtask

  // ------
  // tests
  // ------
  initial begin
    logic [13:0] e;
    boot({2'h0, 2'h1, 2'h0, 1'h0, 2'h2, 3'h6}, 1'b1);
    `CHK("gp_mode", 14'h2606, gp_mode)
    `CHK("drive", 2'h2, drive_strength)
    `CHK("pin_oe", 14'h10B1, pin_oe)
    `CHK("pin_out", 14'h1091, pin_out & pin_oe)
    `CHK("scl sda", 2'h2, {sda_in, scl_in})
    func = 9'h07A;
    step(3);
    `CHK("ded low", 2'h0, {pin_out[12], pin_out[0]})
    func = 9'h17E;
    step(3);
    `CHK("ded high", 2'h3, {pin_out[12], pin_out[0]})
    ext_oe = 14'h0808;
    step(8);
    `CHK("rxd wake", 2'h1, {uart_rxd, remote_wake})
    ext_oe = 14'h0100;
    step(8);
    `CHK("rxd wake", 2'h3, {uart_rxd, remote_wake})
    $display("test defaults done");
    io_wr(14'h0003, 14'h0003, 14'h0002);
    `CHK("io out", 4'hF, {pin_oe[1:0], pin_out[1:0]})
    io_wr(14'h0004, 14'h0000, 14'h0000);
    for (int v = 0; v < 2; v++) begin
      ext_oe = 14'h0004;
      ext_val = {11'h000, v[0], 2'h0};
      step(6);
      `CHK("io level", v[0], host_io_level[2])
    end
    ext_oe = 14'h0000;
    $display("test io done");
    fn_wr(14'h0061, 14'h0061);
    `CHK("gp_mode", 14'h2607, gp_mode)
    `CHK("pin0 kept", 1'b0, pin_oe[0])
    io_wr(14'h0001, 14'h0001, 14'h0000);
    `CHK("pin0", 2'h2, {pin_oe[0], pin_out[0]})
    i2c_if_en = 1'b0;
    fn_wr(14'h0061, 14'h0060);
    `CHK("gp_mode", 14'h2666, gp_mode)
    `CHK("pin0", 1'b1, pin_out[0])
    $display("test fn done");
    rst_req = 1'b1;
    step(8);
    `CHK("ext reset", 16'h8000, {int_reset, cfg_loaded, gp_mode})
    rst_req = 1'b0;
    wait_load();
    `CHK("gp_mode", 14'h2606, gp_mode)
    $display("test ext reset done");
    for (int s = 0; s < 4; s++) begin
      boot({s[1:0], s[1:0], s[1:0], s[0], s[1:0], 3'h1}, 1'b0);
      fn_wr(14'h0060, 14'h0060);
      e = 14'h2E1E | {5'h00, s[0], 7'h00, s[1]} | (s == 3 ? 14'h1080 : 14'h0000);
      `CHK("gp_mode", e, gp_mode)
      `CHK("drive", s[1:0], drive_strength)
      `CHK("oe3", OE_TBL[3*s +: 3], oe3)
      `CHK("out3", OUT_TBL[3*s +: 3], {pin_out[12], pin_out[7], pin_out[0]} & oe3)
    end
    $display("test selections done");
    wrap_up();
  end
endmodule

bind dpm_mux dpm_mux_chk chk (.core_clk, .srst, .ext_reset_low, .cfg_valid, .cfg, .i2c_if_en,
  .func, .host_fn_wr, .host_fn_mask, .host_io_wr, .host_io_mask, .host_io_dir, .host_io_val,
  .pin_in, .pin_out, .pin_oe, .gp_mode, .cfg_loaded, .drive_strength, .remote_wake, .int_reset);
`default_nettype wire

// >>> verilog/dpm_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpm_params.svh"

module dpm_mux (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               ext_reset_low,
  input  wire logic               cfg_valid,
  input  wire dpm_pkg::dpm_fuse_s cfg,
  input  wire logic               uart_if_en,
  input  wire logic               i2c_if_en,
  input  wire dpm_pkg::dpm_func_s func,
  input  wire logic               host_fn_wr,
  input  wire logic [13:0]        host_fn_mask,
  input  wire logic [13:0]        host_fn_gp,
  input  wire logic               host_io_wr,
  input  wire logic [13:0]        host_io_mask,
  input  wire logic [13:0]        host_io_dir,
  input  wire logic [13:0]        host_io_val,
  input  wire logic [13:0]        pin_in,
  output logic [13:0]             pin_out,
  output logic [13:0]             pin_oe,
  output logic [13:0]             host_io_level,
  output logic [13:0]             gp_mode,
  output logic                    cfg_loaded,
  output logic [1:0]              drive_strength,
  output logic                    uart_rxd,
  output logic                    scl_in,
  output logic                    sda_in,
  output logic                    remote_wake,
  output logic                    int_reset
);
  import dpm_pkg::*;

  localparam int NPIN = `DPM_PIN_COUNT;

  dpm_state_s  st;
  dpm_state_s  next_st;
  logic [13:0] fn_out;
  logic [13:0] fn_oe;
  logic [13:0] level;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // pins that start in general-purpose mode after the parameters load
  function automatic logic [13:0] default_gp(input dpm_fuse_s f, input logic uart);
    logic [13:0] m;
    m     = `DPM_ALWAYS_GP;
    m[11] = ~f.ri_on_pin11;
    m[3]  = ~uart;
    m[4]  = ~uart;
    m[0]  = (f.pin0_sel == `DPM_SEL_FN2) || (f.pin0_sel == `DPM_SEL_GPIO);
    m[7]  = (f.pin7_sel == `DPM_SEL_GPIO);
    m[8]  = (f.pin8_sel != `DPM_PIN8_WAKE);
    m[12] = (f.pin12_sel == `DPM_SEL_GPIO);
    return m;                                                 // pins 5,6 stay i2c
  endfunction

  // pins that a host request may move into general-purpose mode
  function automatic logic [13:0] gp_allowed(input logic i2c, input logic eeprom);
    logic [13:0] m;
    m    = 14'h3FFF;
    m[5] = ~i2c & ~eeprom;
    m[6] = ~i2c & ~eeprom;
    return m;
  endfunction

  // ----------------------------------------------------------------------------
  // control state update
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [13:0] allow;
    logic [13:0] upd;
    next_st          = st;
    upd              = '0;
    allow            = gp_allowed(i2c_if_en, st.fuse.eeprom_present);
    next_st.rst_sync = {st.rst_sync[1:0], ext_reset_low};
    if (st.rst_sync[1] == st.rst_sync[2]) begin
      next_st.rst_low = ~st.rst_sync[2];
    end
    if (st.rst_low) begin
      // external reset clears all but the reset pin sampler
      next_st.loaded  = 1'b0;
      next_st.fuse    = '0;
      next_st.uart_en = 1'b0;
      next_st.gp_mode = `DPM_GP_RESET;
      next_st.gp_dir  = '0;
      next_st.gp_val  = '0;
      next_st.wake    = 1'b0;
    end else if (!st.loaded) begin
      if (cfg_valid) begin
        next_st.loaded  = 1'b1;
        next_st.fuse    = cfg;
        next_st.uart_en = uart_if_en;
        next_st.gp_mode = default_gp(cfg, uart_if_en);
      end
    end else begin
      if (host_fn_wr) begin
        upd             = host_fn_mask & (~host_fn_gp | allow);
        next_st.gp_mode = (st.gp_mode & ~upd) | (host_fn_gp & upd);
      end
      if (host_io_wr) begin
        upd            = host_io_mask & st.gp_mode;
        next_st.gp_dir = (st.gp_dir & ~upd) | (host_io_dir & upd);
        next_st.gp_val = (st.gp_val & ~upd) | (host_io_val & upd);
      end
      // wake sources are active low inputs
      next_st.wake = (~st.gp_mode[8] & ~level[8]) |
                     (~st.gp_mode[11] & st.fuse.ri_on_pin11 &
                      st.fuse.ri_wake_en & ~level[11]);
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st          <= '0;
      st.rst_sync <= `DPM_SYNC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------------
  // per-pin function selection
  // ----------------------------------------------------------------------------
  always_comb begin
    fn_out = '0;
    fn_oe  = '0;
    for (int i = 0; i < NPIN; i++) begin
      if (!st.loaded) begin
        fn_oe[i] = 1'b0;  // pins float until parameters apply
      end else if (st.gp_mode[i]) begin
        fn_out[i] = st.gp_val[i];
        fn_oe[i]  = st.gp_dir[i];
      end else begin
        case (i)
          0: begin
            fn_oe[i]  = 1'b1;
            fn_out[i] = (st.fuse.pin0_sel == `DPM_SEL_FN0) ? func.tx_active
                                                            : func.tx_activity_led;
          end
          4: begin
            fn_oe[i]  = 1'b1;
            fn_out[i] = func.txd;
          end
          5: begin
            fn_oe[i] = func.scl_low;  // open drain, drives low only
          end
          6: begin
            fn_oe[i] = func.sda_low;
          end
          7: begin
            fn_oe[i] = 1'b1;
            case (st.fuse.pin7_sel)
              `DPM_SEL_FN0: fn_out[i] = ~func.suspended;
              `DPM_SEL_FN1: fn_out[i] = func.suspended;
              default:      fn_out[i] = ~func.power_en;
            endcase
          end
          12: begin
            fn_oe[i] = 1'b1;
            case (st.fuse.pin12_sel)
              `DPM_SEL_FN0: fn_out[i] = func.charger_dedicated;
              `DPM_SEL_FN1: fn_out[i] = func.rx_activity_led;
              default:      fn_out[i] = ~func.power_en;
            endcase
          end
          default: begin
            fn_oe[i] = 1'b0;  // inputs: rxd, wake, ring
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pad cells
  // ----------------------------------------------------------------------------
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    dpm_pin_cell u_cell (
      .core_clk (core_clk),
      .srst     (srst),
      .pad_in   (pin_in[g]),
      .fn_out   (fn_out[g]),
      .fn_oe    (fn_oe[g]),
      .pad_out  (pin_out[g]),
      .pad_oe   (pin_oe[g]),
      .level    (level[g])
    );
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign host_io_level  = level;
  assign gp_mode        = st.gp_mode;
  assign cfg_loaded     = st.loaded;
  assign drive_strength = st.fuse.drive;
  assign uart_rxd       = level[3];
  assign scl_in         = level[5];
  assign sda_in         = level[6];
  assign remote_wake    = st.wake;
  assign int_reset      = st.rst_low;

endmodule

`default_nettype wire

// >>> verilog/dpm_params.svh
// Functional notes
// - fourteen digital pins, each a dedicated function or general-purpose io
// - pin 0 picks tx driver enable, tx activity led or general_io_a
// - pins 1,2,9,10,13 default to their general-purpose functions, pin 11 too unless it is the ring input
// - with uart interface off, pins 3 and 4 default to general-purpose io
// - pins 5 and 6 go general-purpose only without i2c and eeprom
// - pin 7 picks suspend low, suspend high, power enable low or general_io_2
// - pin 8 picks remote wake input or general_io_3
// - pin 12 picks charger detect, rx_activity_led, power enable low or general_io_g
// - charger detect output is high when a dedicated charger is found
// - pin 0, 7 and 12 choices come from fuses, loaded before pins drive
// - host requests set general-purpose pin functions and the pins follow
// - drive strength has four levels taken from the configuration parameters
// - tx driver enable is active while the uart transmits
// - power-up reset or low external reset pin resets the logic
// - with uart interface on, pin 3 is receive data and pin 4 transmit
// - pins 5 and 6 default to scl and sda, open drain
// - pin 11 as ring input wakes the host when its wake parameter is set
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

// ----------------------------------------------------------------------------
// pin map and selection codes
// ----------------------------------------------------------------------------
`define DPM_PIN_COUNT     14
`define DPM_SEL_W         2
`define DPM_SEL_FN0       2'h0
`define DPM_SEL_FN1       2'h1
`define DPM_SEL_FN2       2'h2
`define DPM_SEL_GPIO      2'h3
`define DPM_PIN8_WAKE     1'h0

// ----------------------------------------------------------------------------
// reset values and load defaults
// ----------------------------------------------------------------------------
`define DPM_SYNC_IDLE     3'h7
`define DPM_GP_RESET      14'h0000
`define DPM_ALWAYS_GP     14'h2606

`endif

// >>> verilog/dpm_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module dpm_pin_cell (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic pad_in,
  input  wire logic fn_out,
  input  wire logic fn_oe,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      level
);
  import dpm_pkg::*;

  dpm_cell_s st;
  dpm_cell_s next_st;

  // ----------------------------------------------------------------------------
  // input sampling and registered drive
  // ----------------------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.sync = {st.sync[1:0], pad_in};
    if (st.sync[1] == st.sync[2]) begin  // change counts once stages agree
      next_st.level = st.sync[2];
    end
    next_st.out = fn_out;
    next_st.oe  = fn_oe;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pad_out = st.out;
  assign pad_oe  = st.oe;
  assign level   = st.level;

endmodule

`default_nettype wire

// >>> verilog/dpm_pkg.sv
`include "dpm_params.svh"
`default_nettype none

package dpm_pkg;

  typedef enum logic [1:0] {
    DPM_DRV_4MA,
    DPM_DRV_8MA,
    DPM_DRV_12MA,
    DPM_DRV_16MA
  } dpm_drive_e;

  // configuration parameters loaded at power-up
  typedef struct packed {
    logic [1:0] pin0_sel;
    logic [1:0] pin7_sel;
    logic [1:0] pin12_sel;
    logic       pin8_sel;
    dpm_drive_e drive;
    logic       ri_on_pin11;
    logic       ri_wake_en;
    logic       eeprom_present;
  } dpm_fuse_s;

  // levels offered by the neighbouring function blocks
  typedef struct packed {
    logic tx_active;
    logic tx_activity_led;
    logic rx_activity_led;
    logic txd;
    logic suspended;
    logic power_en;
    logic charger_dedicated;
    logic scl_low;
    logic sda_low;
  } dpm_func_s;

  // one pad cell
  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       out;
    logic       oe;
  } dpm_cell_s;

  // pin mux control state
  typedef struct packed {
    logic        loaded;
    dpm_fuse_s   fuse;
    logic        uart_en;
    logic [13:0] gp_mode;
    logic [13:0] gp_dir;
    logic [13:0] gp_val;
    logic [2:0]  rst_sync;
    logic        rst_low;
    logic        wake;
  } dpm_state_s;

endpackage

`default_nettype wire
